// File: verilog/msr_pkg.sv
package msr_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] ADDR_FAN     = 8'h22;
    localparam logic [7:0] ADDR_MIXED   = 8'h23;
    localparam logic [7:0] ADDR_PINS    = 8'h24;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;

    // Mixed register field positions
    localparam int BIT_INT_TEMP  = 0;
    localparam int BIT_BATTERY   = 1;
    localparam int BIT_AIN8      = 2;
    localparam int BIT_ALARM     = 3;
    localparam int BIT_FAN_REG   = 4;
    localparam int BIT_UNUSED    = 5;
    localparam int BIT_INTRUSION = 6;
    localparam int BIT_PIN16     = 7;

    // ********************************************************
    // General pins and polarity fields
    // ********************************************************
    localparam int LOW_PINS     = 8;
    localparam int PIN_COUNT    = 9;
    localparam int PIN16_IDX    = 8;
    localparam int PINS_PER_CFG = 4;
    localparam int POL_OFS      = 1;
    localparam int POL_STRIDE   = 2;

    // ********************************************************
    // Serial management bus
    // ********************************************************
    // Arbitrary default, not tied to any product
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C;
    localparam logic [3:0] BIT_CNT_ZERO     = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE      = 4'h1;
    localparam logic [3:0] BIT_CNT_BYTE     = 4'h8;
    localparam int         SYNC_WIDTH       = 12;

    typedef enum logic [8:0] {
        SMB_IDLE  = 9'h001,
        SMB_ADDR  = 9'h002,
        SMB_AACK  = 9'h004,
        SMB_PTR   = 9'h008,
        SMB_PACK  = 9'h010,
        SMB_WDATA = 9'h020,
        SMB_WACK  = 9'h040,
        SMB_RDATA = 9'h080,
        SMB_RACK  = 9'h100
    } msr_smb_state_t;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic       fan_valid;
        logic [7:0] fan_over;
        logic       int_valid;
        logic       int_out;
        logic       bat_valid;
        logic       bat_out;
        logic       ain8_valid;
        logic       ain8_out;
    } msr_meas_t;

    typedef struct packed {
        logic int_alarm_edge;
        logic any_alarm_edge;
        logic fan_reg_edge;
        logic intrusion_clear;
    } msr_evt_t;

    typedef struct packed {
        logic [8:0] dir_out;
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
        logic       pol16;
    } msr_pincfg_t;

endpackage

// File: verilog/msr_sync.sv
`timescale 1ns/100ps
module msr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,   // Device clock
    input  wire logic             rstn,      // Sync reset, active low
    input  wire logic [WIDTH-1:0] async_in,  // Foreign-domain levels
    output logic      [WIDTH-1:0] sync_out   // Two-stage synchronised
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // ********************************************************
    // Two flops; first stage read only by the second
    // ********************************************************
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule // msr_sync

// File: verilog/msr_status_regs.sv
`timescale 1ns/100ps
module msr_status_regs #(
    parameter logic [6:0] DEV_ADDR = msr_pkg::DEV_ADDR_DEFAULT
) (
    input  wire logic                 sys_clk,       // Device clock, 200 MHz
    input  wire logic                 rstn,          // Sync reset, active low
    input  wire msr_pkg::msr_meas_t   meas,          // Conversion results
    input  wire msr_pkg::msr_evt_t    evt,           // Alarm and fan events
    input  wire msr_pkg::msr_pincfg_t pin_cfg,       // Pin direction, polarity
    input  wire logic                 intrusion_pin, // Chassis intrusion level
    input  wire logic                 scl_in,        // Bus clock pin
    input  wire logic                 sda_in,        // Bus data pin level
    output logic                      sda_out,       // Bus data drive value
    output logic                      sda_oe_n,      // Bus data enable, low drives
    input  wire logic [8:0]           pin_in,        // General pins 0-7 and 16
    output logic      [8:0]           pin_out,       // General pin drive levels
    output logic      [8:0]           pin_oe_n       // Pin enables, low drives
);

    // ********************************************************
    // Synchronised pins
    // ********************************************************
    logic [msr_pkg::SYNC_WIDTH-1:0] sync_bus;
    logic                           scl_s;
    logic                           sda_s;
    logic                           intr_s;
    logic [8:0]                     pin_s;

    msr_sync #(
        .WIDTH (msr_pkg::SYNC_WIDTH)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in ({intrusion_pin, scl_in, sda_in, pin_in}),
        .sync_out (sync_bus)
    );

    assign pin_s  = sync_bus[8:0];
    assign sda_s  = sync_bus[9];
    assign scl_s  = sync_bus[10];
    assign intr_s = sync_bus[11];

    // ********************************************************
    // Bus edge detection
    // ********************************************************
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_d_reg;
    assign scl_fall   = ~scl_s & scl_d_reg;
    assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_seen  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ********************************************************
    // Status storage
    // ********************************************************
    logic [7:0] fan_reg;
    logic       int_bit_reg;
    logic       bat_bit_reg;
    logic       ain8_bit_reg;
    logic       alarm_bit_reg;
    logic       fanreg_bit_reg;
    logic       intr_bit_reg;
    logic [8:0] drv_reg;
    logic [8:0] pin_stat_reg;
    logic [8:0] pol;
    logic [7:0] mixed_rd;
    logic [7:0] rd_data;
    logic       wr_pulse_reg;
    logic       rd_pulse_reg;
    logic [7:0] ptr_reg;
    logic [7:0] shift_reg;
    logic       wr_pins;
    logic       wr_mixed;
    logic       rd_mixed;

    assign wr_pins  = wr_pulse_reg && (ptr_reg == msr_pkg::ADDR_PINS);
    assign wr_mixed = wr_pulse_reg && (ptr_reg == msr_pkg::ADDR_MIXED);
    assign rd_mixed = rd_pulse_reg && (ptr_reg == msr_pkg::ADDR_MIXED);

    always_comb
    begin
        for (int i = 0; i < msr_pkg::LOW_PINS; i++)
        begin
            if (i < msr_pkg::PINS_PER_CFG)
                pol[i] = pin_cfg.cfg_a[i * msr_pkg::POL_STRIDE + msr_pkg::POL_OFS];
            else
                pol[i] = pin_cfg.cfg_b[(i - msr_pkg::PINS_PER_CFG) * msr_pkg::POL_STRIDE + msr_pkg::POL_OFS];
        end
        pol[msr_pkg::PIN16_IDX] = pin_cfg.pol16;
    end

    // fan limit capture, cleared by reset
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            fan_reg <= msr_pkg::STATUS_RESET;
        else if (meas.fan_valid)
            fan_reg <= meas.fan_over;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            int_bit_reg <= 1'b0;
        else if (evt.int_alarm_edge)
            int_bit_reg <= 1'b1;
        else if (meas.int_valid)
            int_bit_reg <= meas.int_out;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            bat_bit_reg  <= 1'b0;
            ain8_bit_reg <= 1'b0;
        end
        else
        begin
            if (meas.bat_valid)
                bat_bit_reg <= meas.bat_out;
            if (meas.ain8_valid)
                ain8_bit_reg <= meas.ain8_out;
        end
    end

    // event bits, cleared by reading, set wins
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            alarm_bit_reg  <= 1'b0;
            fanreg_bit_reg <= 1'b0;
        end
        else
        begin
            if (evt.any_alarm_edge)
                alarm_bit_reg <= 1'b1;
            else if (rd_mixed)
                alarm_bit_reg <= 1'b0;
            if (evt.fan_reg_edge)
                fanreg_bit_reg <= 1'b1;
            else if (rd_mixed)
                fanreg_bit_reg <= 1'b0;
        end
    end

    // intrusion latch; clear only from outside, set wins
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            intr_bit_reg <= 1'b0;
        else if (intr_s)
            intr_bit_reg <= 1'b1;
        else if (evt.intrusion_clear)
            intr_bit_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            drv_reg <= '0;
        else
        begin
            for (int i = 0; i < msr_pkg::LOW_PINS; i++)
                if (wr_pins && pin_cfg.dir_out[i])
                    drv_reg[i] <= shift_reg[i];
            if (wr_mixed && pin_cfg.dir_out[msr_pkg::PIN16_IDX])
                drv_reg[msr_pkg::PIN16_IDX] <= shift_reg[msr_pkg::BIT_PIN16];
        end
    end

    // input pins read asserted per polarity
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            pin_stat_reg <= '0;
        else
        begin
            for (int i = 0; i < msr_pkg::PIN_COUNT; i++)
                pin_stat_reg[i] <= pin_cfg.dir_out[i] ? drv_reg[i] : ~(pin_s[i] ^ pol[i]);
        end
    end

    // pin drive; polarity 1 means active high
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end
        else
        begin
            pin_out  <= ~(drv_reg ^ pol);
            pin_oe_n <= ~pin_cfg.dir_out;
        end
    end

    always_comb
    begin
        mixed_rd                          = msr_pkg::STATUS_RESET;
        mixed_rd[msr_pkg::BIT_INT_TEMP]   = int_bit_reg;
        mixed_rd[msr_pkg::BIT_BATTERY]    = bat_bit_reg;
        mixed_rd[msr_pkg::BIT_AIN8]       = ain8_bit_reg;
        mixed_rd[msr_pkg::BIT_ALARM]      = alarm_bit_reg;
        mixed_rd[msr_pkg::BIT_FAN_REG]    = fanreg_bit_reg;
        mixed_rd[msr_pkg::BIT_INTRUSION]  = intr_bit_reg;
        mixed_rd[msr_pkg::BIT_PIN16]      = pin_stat_reg[msr_pkg::PIN16_IDX];
    end

    always_comb
    begin
        if (ptr_reg == msr_pkg::ADDR_FAN)
            rd_data = fan_reg;
        else if (ptr_reg == msr_pkg::ADDR_MIXED)
            rd_data = mixed_rd;
        else if (ptr_reg == msr_pkg::ADDR_PINS)
            rd_data = pin_stat_reg[7:0];
        else
            rd_data = msr_pkg::RD_UNMAPPED;
    end

    // ********************************************************
    // Bus slave: write byte, read byte, receive byte
    // ********************************************************
    msr_pkg::msr_smb_state_t state_reg;
    logic [3:0]              bit_cnt_reg;
    logic                    is_read_reg;
    logic                    sda_oe_n_reg;

    // Open drain: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = sda_oe_n_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_reg    <= msr_pkg::SMB_IDLE;
            bit_cnt_reg  <= msr_pkg::BIT_CNT_ZERO;
            shift_reg    <= msr_pkg::STATUS_RESET;
            ptr_reg      <= msr_pkg::STATUS_RESET;
            is_read_reg  <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            wr_pulse_reg <= 1'b0;
            rd_pulse_reg <= 1'b0;
        end
        else
        begin
            wr_pulse_reg <= 1'b0;
            rd_pulse_reg <= 1'b0;
            if (stop_seen)
            begin
                state_reg    <= msr_pkg::SMB_IDLE;
                sda_oe_n_reg <= 1'b1;
            end
            else if (start_seen)
            begin
                state_reg    <= msr_pkg::SMB_ADDR;
                bit_cnt_reg  <= msr_pkg::BIT_CNT_ZERO;
                sda_oe_n_reg <= 1'b1;
            end
            else if (scl_rise)
            begin
                case (state_reg)
                    msr_pkg::SMB_ADDR, msr_pkg::SMB_PTR, msr_pkg::SMB_WDATA:
                    begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + msr_pkg::BIT_CNT_ONE;
                    end
                    msr_pkg::SMB_RDATA:
                        bit_cnt_reg <= bit_cnt_reg + msr_pkg::BIT_CNT_ONE;
                    // Master not-acknowledge ends the read
                    msr_pkg::SMB_RACK:
                        if (sda_s)
                            state_reg <= msr_pkg::SMB_IDLE;
                    default:
                        state_reg <= state_reg;
                endcase
            end
            else if (scl_fall)
            begin
                case (state_reg)
                    msr_pkg::SMB_ADDR:
                        if (bit_cnt_reg == msr_pkg::BIT_CNT_BYTE)
                        begin
                            if (shift_reg[7:1] == DEV_ADDR)
                            begin
                                state_reg    <= msr_pkg::SMB_AACK;
                                is_read_reg  <= shift_reg[0];
                                sda_oe_n_reg <= 1'b0;
                            end
                            else
                                state_reg <= msr_pkg::SMB_IDLE;
                        end
                    msr_pkg::SMB_PTR:
                        if (bit_cnt_reg == msr_pkg::BIT_CNT_BYTE)
                        begin
                            ptr_reg      <= shift_reg;
                            state_reg    <= msr_pkg::SMB_PACK;
                            sda_oe_n_reg <= 1'b0;
                        end
                    // data lands only through the gated stores
                    msr_pkg::SMB_WDATA:
                        if (bit_cnt_reg == msr_pkg::BIT_CNT_BYTE)
                        begin
                            wr_pulse_reg <= 1'b1;
                            state_reg    <= msr_pkg::SMB_WACK;
                            sda_oe_n_reg <= 1'b0;
                        end
                    msr_pkg::SMB_AACK, msr_pkg::SMB_RACK:
                    begin
                        bit_cnt_reg <= msr_pkg::BIT_CNT_ZERO;
                        if (is_read_reg)
                        begin
                            state_reg    <= msr_pkg::SMB_RDATA;
                            shift_reg    <= rd_data;
                            rd_pulse_reg <= 1'b1;
                            sda_oe_n_reg <= rd_data[7];
                        end
                        else
                        begin
                            state_reg    <= msr_pkg::SMB_PTR;
                            sda_oe_n_reg <= 1'b1;
                        end
                    end
                    // No auto-increment: repeated bytes go to one register
                    msr_pkg::SMB_PACK, msr_pkg::SMB_WACK:
                    begin
                        bit_cnt_reg  <= msr_pkg::BIT_CNT_ZERO;
                        state_reg    <= msr_pkg::SMB_WDATA;
                        sda_oe_n_reg <= 1'b1;
                    end
                    msr_pkg::SMB_RDATA:
                        if (bit_cnt_reg == msr_pkg::BIT_CNT_BYTE)
                        begin
                            state_reg    <= msr_pkg::SMB_RACK;
                            sda_oe_n_reg <= 1'b1;
                        end
                        else
                        begin
                            sda_oe_n_reg <= shift_reg[6];
                            shift_reg    <= {shift_reg[6:0], 1'b0};
                        end
                    default:
                        state_reg <= state_reg;
                endcase
            end
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_pin0_write;
        wr_pins && pin_cfg.dir_out[0] && shift_reg[0];
    endsequence

    sequence s_pin0_stable_cfg;
        $stable(pin_cfg.cfg_a) [*2];
    endsequence

    AST_FAN_CAPTURE: assert property (meas.fan_valid |=> fan_reg == $past(meas.fan_over))
        else $error("fan status did not capture conversion result");
    AST_INT_LIMIT: assert property (meas.int_valid && !evt.int_alarm_edge |=> int_bit_reg == $past(meas.int_out))
        else $error("internal temperature bit wrong after conversion");
    AST_INT_ALARM: assert property (evt.int_alarm_edge |=> mixed_rd[msr_pkg::BIT_INT_TEMP])
        else $error("internal temperature bit not set by alarm edge");
    AST_BAT_LIMIT: assert property (meas.bat_valid |=> mixed_rd[msr_pkg::BIT_BATTERY] == $past(meas.bat_out))
        else $error("battery bit wrong after conversion");
    AST_ALARM_SET: assert property (evt.any_alarm_edge |=> alarm_bit_reg)
        else $error("alarm bit not set by alarm edge");
    AST_FANREG_SET: assert property (evt.fan_reg_edge |=> fanreg_bit_reg)
        else $error("fan regulation bit not set by event");
    AST_UNUSED_ZERO: assert property (rd_data[msr_pkg::BIT_UNUSED] == 1'b0 || ptr_reg != msr_pkg::ADDR_MIXED)
        else $error("unused bit read as one");
    AST_INTR_HOLD: assert property (intr_bit_reg && !evt.intrusion_clear |=> intr_bit_reg)
        else $error("intrusion latch dropped");
    AST_PIN_DRIVE: assert property (s_pin0_write ##0 s_pin0_stable_cfg |=> ##1 pin_out[0] == pol[0])
        else $error("output pin 0 not asserted after write");
    AST_RO_FAN: assert property (wr_pulse_reg && !meas.fan_valid |=> $stable(fan_reg))
        else $error("write changed read-only fan status");
    AST_INPUT_NO_WRITE: assert property (wr_pins && !pin_cfg.dir_out[0] |=> $stable(drv_reg[0]))
        else $error("input pin accepted a write");

endmodule // msr_status_regs

// File: tb/msr_smb_host.sv
`timescale 1ns/100ps
module msr_smb_host #(
    parameter logic [6:0] ADDR = msr_pkg::DEV_ADDR_DEFAULT
) (
    sys_clk,  // Device clock, paces the bus
    sda_line, // Resolved data line level
    scl,      // Bus clock, idles high
    sda_rel   // 1 releases data, 0 pulls low
);
    input  wire logic sys_clk;
    input  wire logic sda_line;
    output logic      scl = 1'b1;
    output logic      sda_rel = 1'b1;

    // ****************
    // Bus phases
    // ****************
    // Quarter of a 160 ns link period
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic bit_io(input logic b, output logic got);
        sda_rel = b;
        wt(8);
        scl = 1'b1;
        wt(8);
        got = sda_line;
        wt(8);
        scl = 1'b0;
        wt(8);
    endtask

    task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ak, a);
    endtask

    task automatic start();
        sda_rel = 1'b1;
        wt(8);
        scl = 1'b1;
        wt(8);
        sda_rel = 1'b0;
        wt(8);
        scl = 1'b0;
        wt(8);
    endtask

    task automatic stop();
        sda_rel = 1'b0;
        wt(8);
        scl = 1'b1;
        wt(8);
        sda_rel = 1'b1;
        wt(16);
    endtask

    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic nak);
        logic [7:0] q;
        logic       a0, a1, a2;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(ptr, 1'b1, q, a1);
        byte_io(d, 1'b1, q, a2);
        stop();
        nak = a0 | a1 | a2;
    endtask

    task automatic rd_reg(input logic [7:0] ptr, output logic [8:0] r);
        logic [7:0] q;
        logic       a0, a1, a2, a3;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(ptr, 1'b1, q, a1);
        start();
        byte_io({ADDR, 1'b1}, 1'b1, q, a2);
        // Master ends with a not-acknowledge
        byte_io(8'hFF, 1'b1, q, a3);
        stop();
        r = {a0 | a1 | a2, q};
    endtask
endmodule // msr_smb_host

// File: tb/test_monitor_status_regs_three_to_five.sv
`timescale 1ns/100ps
module test_monitor_status_regs_three_to_five;
    logic                sys_clk = 1'b0;
    logic                rstn;
    msr_pkg::msr_meas_t   meas;
    msr_pkg::msr_evt_t    evt;
    msr_pkg::msr_pincfg_t cfg;
    logic                intrusion_pin;
    logic [8:0]          pin_ext, pin_in, pin_out, pin_oe_n, p;
    logic                scl, sda_rel, sda_line, sda_out, sda_oe_n;
    int                  failures = 0;
    int                  checks_done = 0;

    always #2.5 sys_clk = ~sys_clk;
    // Pull-up on data; driven pins show the device level
    assign sda_line = sda_rel & (sda_oe_n | sda_out);
    assign pin_in   = (pin_oe_n & pin_ext) | (~pin_oe_n & pin_out);

    msr_status_regs DUT (.sys_clk(sys_clk), .rstn(rstn), .meas(meas), .evt(evt), .pin_cfg(cfg),
        .intrusion_pin(intrusion_pin), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    msr_smb_host host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

    // ****************
    // Checks
    // ****************
    task automatic close_out();
        $display("Counts: %0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] r;
        host.rd_reg(a, r);
        chk(r, {1'b0, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic nak;
        host.wr_reg(a, d, nak);
        chk({8'h00, nak}, 9'h000);
    endtask

    task automatic pulse(input msr_pkg::msr_evt_t e);
        evt = e;
        host.wt(1);
        evt = '0;
    endtask

    task automatic strobe(input msr_pkg::msr_meas_t m);
        meas = m;
        host.wt(1);
        meas = '0;
        host.wt(2);
    endtask

    // Polarity bit of pin n sits at 2*(n%4)+1
    always_comb
    begin
        for (int n = 0; n < 8; n++)
            p[n] = (n < 4) ? cfg.cfg_a[2*(n%4)+1] : cfg.cfg_b[2*(n%4)+1];
        p[8] = cfg.pol16;
    end

    // ****************
    // Tests
    // ****************
    initial
    begin
        #400000;
        failures++;
        close_out();
    end

    initial
    begin
        rstn = 1'b0;
        meas = '0;
        evt = '0;
        cfg = '0;
        intrusion_pin = 1'b0;
        pin_ext = 9'h1FF;
        repeat (4) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        host.wt(4);
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h00);
        rd(8'h24, 8'h00);
        rd(8'h30, 8'h00);
        strobe('{fan_valid: 1'b1, fan_over: 8'hA5, default: '0});
        rd(8'h22, 8'hA5);
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'hA5);
        strobe('{fan_valid: 1'b1, fan_over: 8'h3C, default: '0});
        rd(8'h22, 8'h3C);
        intrusion_pin = 1'b1;
        strobe('{int_valid: 1'b1, int_out: 1'b1, bat_valid: 1'b1, bat_out: 1'b1, ain8_valid: 1'b1, default: '0});
        intrusion_pin = 1'b0;
        rd(8'h23, 8'h43);
        wr(8'h23, 8'h7F);
        rd(8'h23, 8'h43);
        strobe('{int_valid: 1'b1, bat_valid: 1'b1, ain8_valid: 1'b1, ain8_out: 1'b1, default: '0});
        rd(8'h23, 8'h44);
        pulse('{int_alarm_edge: 1'b1, default: 1'b0});
        rd(8'h23, 8'h45);
        pulse('{any_alarm_edge: 1'b1, default: 1'b0});
        rd(8'h23, 8'h4D);
        pulse('{fan_reg_edge: 1'b1, default: 1'b0});
        rd(8'h23, 8'h55);
        pulse('{any_alarm_edge: 1'b1, fan_reg_edge: 1'b1, default: 1'b0});
        rd(8'h23, 8'h5D);
        rd(8'h23, 8'h45);
        pulse('{intrusion_clear: 1'b1, default: 1'b0});
        rd(8'h23, 8'h05);
        cfg.cfg_a = 8'h22;
        cfg.cfg_b = 8'h88;
        cfg.pol16 = 1'b1;
        pin_ext = 9'h1F3;
        host.wt(4);
        rd(8'h24, ~(pin_ext[7:0] ^ p[7:0]));
        rd(8'h23, 8'h85);
        wr(8'h24, 8'h00);
        rd(8'h24, ~(pin_ext[7:0] ^ p[7:0]));
        cfg.dir_out = 9'h12F;
        host.wt(2);
        wr(8'h24, 8'h05);
        chk(pin_oe_n, 9'h0D0);
        chk(pin_out & 9'h00F, {5'h00, ~(4'h5 ^ p[3:0])});
        chk(pin_out & 9'h020, {3'h0, ~p[5], 5'h00});
        rd(8'h24, {~(pin_ext[7:6] ^ p[7:6]), 1'b0, ~(pin_ext[4] ^ p[4]), 4'h5});
        wr(8'h23, 8'h80);
        chk(pin_out & 9'h100, 9'h100);
        rd(8'h23, 8'h85);
        cfg.pol16 = 1'b0;
        host.wt(3);
        chk(pin_out & 9'h100, 9'h000);
        close_out();
    end
endmodule // test_monitor_status_regs_three_to_five
